// File: logic/acrc_map.vh
// Purpose: constants for the calibration and register-map check block
// Assumes: byte-wide register file with 4-bit addresses
// Notes: offsets are register indices on the serial register port
`ifndef ACRC_MAP_VH
`define ACRC_MAP_VH
`define ACRC_ADDR_CONFIG 4'h8
`define ACRC_ADDR_OFS_HI 4'h9
`define ACRC_ADDR_OFS_MID 4'hA
`define ACRC_ADDR_OFS_LO 4'hB
`define ACRC_ADDR_GAIN_HI 4'hC
`define ACRC_ADDR_GAIN_MID 4'hD
`define ACRC_ADDR_GAIN_LO 4'hE
`define ACRC_ADDR_CHECKSUM 4'hF
`define ACRC_ADDR_STATUS 4'h2
`define ACRC_CFG_CHECK_EN_BIT 1
`define ACRC_STAT_MAP_FAULT_BIT 5
`define ACRC_RST_OFS 8'h00
`define ACRC_RST_GAIN_HI 8'h40
`define ACRC_RST_GAIN_LO 8'h00
`define ACRC_RST_CHECKSUM 8'h00
`define ACRC_RST_CONFIG 8'h00
`define ACRC_CFG_RSVD_MASK 8'hEF
`define ACRC_GAIN_SHIFT 22
`define ACRC_CRC_POLY 8'h07
`define ACRC_CRC_INIT 8'hFF
`endif

// File: logic/acrc_cal_regmap.v
// Purpose: user offset/gain calibration and register-map checksum check
// Assumes: the serial front end delivers decoded byte accesses on clk;
//          conversion results arrive as a one-cycle strobe on clk
// Notes: registers 0h,1h,4h..7h live elsewhere and arrive as a bus;
//        checksum kind is a parameterisable crc-8
//        fault is a live level, not sticky: it clears on a match
//        gain floors toward minus infinity, no rounding stage
//        result saturates rather than wraps on any overflow
//        a half-written offset or gain word is live until completed
//        status index 2h and fault bit 5 are local choices
`timescale 1ns/1ns
`default_nettype none
`include "acrc_map.vh"

module acrc_cal_regmap #(
    parameter DATA_W = 24,
    parameter CRC_POLY = `ACRC_CRC_POLY,
    parameter CRC_INIT = `ACRC_CRC_INIT
) (
    input wire clk,
    input wire rst_b,
    input wire reg_wr,
    input wire reg_rd,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    input wire [47:0] ext_regs,
    input wire [7:0] ext_status,
    input wire raw_valid,
    input wire [DATA_W-1:0] raw_data,
    output reg cal_valid,
    output reg [DATA_W-1:0] cal_data,
    output wire [7:0] status_header,
    output wire map_fault
);

////////////////////////////////////////////////////////////////////////////
reg [7:0] config_reg;
reg [7:0] ofs_hi_reg;
reg [7:0] ofs_mid_reg;
reg [7:0] ofs_lo_reg;
reg [7:0] gain_hi_reg;
reg [7:0] gain_mid_reg;
reg [7:0] gain_lo_reg;
reg [7:0] checksum_reg;
reg fault_reg;
reg [7:0] crc_reg;
wire check_en;
wire [23:0] ofs_word;
wire [23:0] gain_word;

assign check_en = config_reg[`ACRC_CFG_CHECK_EN_BIT];
assign ofs_word = {ofs_hi_reg, ofs_mid_reg, ofs_lo_reg};
assign gain_word = {gain_hi_reg, gain_mid_reg, gain_lo_reg};

reg [7:0] config_next;
reg [7:0] ofs_hi_next;
reg [7:0] ofs_mid_next;
reg [7:0] ofs_lo_next;
reg [7:0] gain_hi_next;
reg [7:0] gain_mid_next;
reg [7:0] gain_lo_next;
reg [7:0] checksum_next;

// each byte applies on its own write; no word staging, so a
// partly written word is live for a few cycles
always @* begin
    config_next = config_reg;
    ofs_hi_next = ofs_hi_reg;
    ofs_mid_next = ofs_mid_reg;
    ofs_lo_next = ofs_lo_reg;
    gain_hi_next = gain_hi_reg;
    gain_mid_next = gain_mid_reg;
    gain_lo_next = gain_lo_reg;
    checksum_next = checksum_reg;
    if (reg_wr) begin
        case (reg_addr)
            `ACRC_ADDR_CONFIG: config_next = reg_wdata & `ACRC_CFG_RSVD_MASK;
            `ACRC_ADDR_OFS_HI: ofs_hi_next = reg_wdata;
            `ACRC_ADDR_OFS_MID: ofs_mid_next = reg_wdata;
            `ACRC_ADDR_OFS_LO: ofs_lo_next = reg_wdata;
            `ACRC_ADDR_GAIN_HI: gain_hi_next = reg_wdata;
            `ACRC_ADDR_GAIN_MID: gain_mid_next = reg_wdata;
            `ACRC_ADDR_GAIN_LO: gain_lo_next = reg_wdata;
            `ACRC_ADDR_CHECKSUM: checksum_next = reg_wdata;
            default: ;
        endcase
    end
end

always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        config_reg <= `ACRC_RST_CONFIG;
        ofs_hi_reg <= `ACRC_RST_OFS;
        ofs_mid_reg <= `ACRC_RST_OFS;
        ofs_lo_reg <= `ACRC_RST_OFS;
        gain_hi_reg <= `ACRC_RST_GAIN_HI;
        gain_mid_reg <= `ACRC_RST_GAIN_LO;
        gain_lo_reg <= `ACRC_RST_GAIN_LO;
        checksum_reg <= `ACRC_RST_CHECKSUM;
    end else begin
        config_reg <= config_next;
        ofs_hi_reg <= ofs_hi_next;
        ofs_mid_reg <= ofs_mid_next;
        ofs_lo_reg <= ofs_lo_next;
        gain_hi_reg <= gain_hi_next;
        gain_mid_reg <= gain_mid_next;
        gain_lo_reg <= gain_lo_next;
        checksum_reg <= checksum_next;
    end
end

////////////////////////////////////////////////////////////////////////////
// checksum over regs 0h,1h,4h..Eh; recomputed combinationally each cycle
function [7:0] crc_byte;
    input [7:0] crc_in;
    input [7:0] data;
    reg [7:0] c;
    integer i;
    begin
        c = crc_in ^ data;
        for (i = 0; i < 8; i = i + 1) begin
            if (c[7]) begin
                c = {c[6:0], 1'b0} ^ CRC_POLY[7:0];
            end else begin
                c = {c[6:0], 1'b0};
            end
        end
        crc_byte = c;
    end
endfunction

// byte order matches the host: 0h,1h,4h..7h then 8h..Eh
reg [7:0] crc_next;
always @* begin
    crc_next = CRC_INIT[7:0];
    crc_next = crc_byte(crc_next, ext_regs[47:40]);
    crc_next = crc_byte(crc_next, ext_regs[39:32]);
    crc_next = crc_byte(crc_next, ext_regs[31:24]);
    crc_next = crc_byte(crc_next, ext_regs[23:16]);
    crc_next = crc_byte(crc_next, ext_regs[15:8]);
    crc_next = crc_byte(crc_next, ext_regs[7:0]);
    crc_next = crc_byte(crc_next, config_reg);
    crc_next = crc_byte(crc_next, ofs_hi_reg);
    crc_next = crc_byte(crc_next, ofs_mid_reg);
    crc_next = crc_byte(crc_next, ofs_lo_reg);
    crc_next = crc_byte(crc_next, gain_hi_reg);
    crc_next = crc_byte(crc_next, gain_mid_reg);
    crc_next = crc_byte(crc_next, gain_lo_reg);
end

// registered crc breaks the long xor chain; compare lags one cycle
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        crc_reg <= 8'h00;
    end else begin
        crc_reg <= crc_next;
    end
end

////////////////////////////////////////////////////////////////////////////
// fault tracks mismatch while enabled; cleared when check disabled
reg fault_next;
always @* begin
    if (check_en) begin
        fault_next = (crc_reg != checksum_reg);
    end else begin
        fault_next = 1'b0;
    end
end

always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        fault_reg <= 1'b0;
    end else begin
        fault_reg <= fault_next;
    end
end

assign map_fault = fault_reg;
// header copy leaves the other status bits untouched
assign status_header = (ext_status & ~(8'h01 << `ACRC_STAT_MAP_FAULT_BIT))
    | ({7'h00, fault_reg} << `ACRC_STAT_MAP_FAULT_BIT);

////////////////////////////////////////////////////////////////////////////
// unmapped indices read as zero rather than stale data
reg [7:0] rdata_next;
always @* begin
    rdata_next = reg_rdata;
    if (reg_rd) begin
        case (reg_addr)
            `ACRC_ADDR_STATUS: rdata_next = status_header;
            `ACRC_ADDR_CONFIG: rdata_next = config_reg;
            `ACRC_ADDR_OFS_HI: rdata_next = ofs_hi_reg;
            `ACRC_ADDR_OFS_MID: rdata_next = ofs_mid_reg;
            `ACRC_ADDR_OFS_LO: rdata_next = ofs_lo_reg;
            `ACRC_ADDR_GAIN_HI: rdata_next = gain_hi_reg;
            `ACRC_ADDR_GAIN_MID: rdata_next = gain_mid_reg;
            `ACRC_ADDR_GAIN_LO: rdata_next = gain_lo_reg;
            `ACRC_ADDR_CHECKSUM: rdata_next = checksum_reg;
            default: rdata_next = 8'h00;
        endcase
    end
end

always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        reg_rdata <= 8'h00;
    end else begin
        reg_rdata <= rdata_next;
    end
end

////////////////////////////////////////////////////////////////////////////
// two pipeline stages: offset, then gain; saturate at each stage
// bounds two bits wider than the data so compares stay signed
localparam signed [DATA_W+1:0] MAXV = (1 <<< (DATA_W-1)) - 1;
localparam signed [DATA_W+1:0] MINV = -(1 <<< (DATA_W-1));

reg s1_valid_reg;
reg signed [DATA_W-1:0] s1_data_reg;
wire signed [DATA_W+1:0] diff;
reg signed [DATA_W-1:0] diff_sat;
wire signed [DATA_W+25:0] prod;
wire signed [DATA_W+25:0] scaled;
reg [DATA_W-1:0] scaled_sat;

// difference is two bits wider, so it never wraps
assign diff = $signed({{2{raw_data[DATA_W-1]}}, raw_data})
    - $signed({{(DATA_W-22){ofs_word[23]}}, ofs_word});
always @* begin
    if (diff > MAXV) begin
        diff_sat = MAXV[DATA_W-1:0];
    end else if (diff < MINV) begin
        diff_sat = MINV[DATA_W-1:0];
    end else begin
        diff_sat = diff[DATA_W-1:0];
    end
end

// 24 by 25 bit magnitude fits the 50-bit product
// gain treated unsigned: zero-extend before signed multiply
assign prod = $signed({{26{s1_data_reg[DATA_W-1]}}, s1_data_reg})
    * $signed({{(DATA_W+2){1'b0}}, gain_word});
assign scaled = prod >>> `ACRC_GAIN_SHIFT;

always @* begin
    if (scaled > $signed({{24{MAXV[DATA_W+1]}}, MAXV})) begin
        scaled_sat = MAXV[DATA_W-1:0];
    end else if (scaled < $signed({{24{MINV[DATA_W+1]}}, MINV})) begin
        scaled_sat = MINV[DATA_W-1:0];
    end else begin
        scaled_sat = scaled[DATA_W-1:0];
    end
end

////////////////////////////////////////////////////////////////////////////
// stage 1: offset-corrected, saturated sample
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        s1_valid_reg <= 1'b0;
        s1_data_reg <= {DATA_W{1'b0}};
    end else begin
        s1_valid_reg <= raw_valid;
        if (raw_valid) begin
            s1_data_reg <= diff_sat;
        end
    end
end

// stage 2: gain-scaled result, held until the next one
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        cal_valid <= 1'b0;
        cal_data <= {DATA_W{1'b0}};
    end else begin
        cal_valid <= s1_valid_reg;
        if (s1_valid_reg) begin
            cal_data <= scaled_sat;
        end
    end
end

endmodule // acrc_cal_regmap
`default_nettype wire

// File: dv/acrc_cal_regmap_props.sv
// Purpose: port checks for the calibration block
// Assumes: one clk domain
// Notes: bound from tb_top
`timescale 1ns/1ns
`default_nettype none
module acrc_cal_regmap_props #(parameter DATA_W = 24) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] ext_status,
    input wire logic raw_valid,
    input wire logic cal_valid,
    input wire logic [DATA_W-1:0] cal_data,
    input wire logic [7:0] status_header,
    input wire logic map_fault
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_cal_latency: assert property (raw_valid |-> ##2 cal_valid)
        else $error("cal_valid missing");
    a_cal_cause: assert property (cal_valid |-> $past(raw_valid, 2))
        else $error("cal_valid without result");
    a_cal_hold: assert property (!cal_valid |-> $stable(cal_data))
        else $error("cal_data moved");
    a_hdr_fault: assert property (status_header[5] == map_fault)
        else $error("header fault bit wrong");
    a_hdr_pass: assert property ((status_header & 8'hDF)
        == (ext_status & 8'hDF))
        else $error("header bits wrong");
    a_rd_hold: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("rdata moved");
    a_rd_unmapped: assert property (reg_rd && reg_addr inside {[4'h3:4'h7]}
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    a_gain_echo: assert property (reg_wr && reg_addr == 4'hC ##1 !reg_wr ##1
        reg_rd && !reg_wr && reg_addr == 4'hC |=> reg_rdata == $past(reg_wdata, 3))
        else $error("gain byte readback wrong");
    a_check_off: assert property ((reg_wr && reg_addr == 4'h8 && !reg_wdata[1])
        ##1 !reg_wr [*2] |-> !map_fault) else $error("fault while disabled");
endmodule // acrc_cal_regmap_props
`default_nettype wire

// File: dv/acrc_host.sv
// Purpose: register-port host with shadow map and checksum
// Assumes: drives on falling clk edge
// Notes: crc-8 poly 07h init FFh as the design chose
`timescale 1ns/1ns
`default_nettype none
module acrc_host (
    input wire logic clk,
    output var logic reg_wr,
    output var logic reg_rd,
    output var logic [3:0] reg_addr,
    output var logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    output var logic [47:0] ext_regs,
    output var logic [7:0] ext_status
);
    logic [7:0] sh [0:15];
    // strobes move on the falling edge, coherent with clk
    // port idles freely between accesses, nothing waits on it
    initial begin
        {reg_wr, reg_rd, reg_addr, reg_wdata} = 14'h0;
        {ext_regs, ext_status} = 56'h0123456789AB81;
        foreach (sh[i]) sh[i] = (i == 12) ? 8'h40 : 8'h00;
    end
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge clk);
        {reg_wr, reg_addr, reg_wdata} = {1'h1, a, d};
        @(negedge clk);
        {reg_wr, reg_wdata} = {1'h0, ~d};
        sh[a] = d;
    endtask
    task rd(input logic [3:0] a, output logic [7:0] d);
        @(negedge clk);
        {reg_rd, reg_addr} = {1'h1, a};
        @(negedge clk);
        reg_rd = 1'h0;
        d = reg_rdata;
    endtask
    // checksum over 0h,1h,4h..Eh in that order
    function automatic logic [7:0] crc();
        logic [7:0] c;
        c = 8'hFF;
        for (int i = 0; i < 13; i++) begin
            c = c ^ (i < 6 ? ext_regs[47 - 8 * i -: 8] : sh[i + 2]);
            for (int k = 0; k < 8; k++) c = {c[6:0], 1'h0} ^ (c[7] ? 8'h07 : 8'h00);
        end
        return c;
    endfunction
endmodule // acrc_host
`default_nettype wire

// File: dv/tb_top.sv
// Purpose: self-checking bench for the calibration block
// Assumes: inputs move on the falling edge
// Notes: no serial clock pin here, link clock not exercised
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic clk, rst_b, reg_wr, reg_rd, raw_valid, cal_valid, map_fault;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, ext_status, status_header, c;
    logic [47:0] ext_regs;
    logic [23:0] raw_data, cal_data;
    int bad_count = 0;
    int n_tests = 0;
    acrc_cal_regmap acrc_cal_regmap_inst (.*);
    acrc_host acrc_host_inst (.*);
    always #2 clk = ~clk;
    task chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s exp %h got %h", nm, e, g);
        end
    endtask
    task rr(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] d;
        acrc_host_inst.rd(a, d);
        chk("rdata", {16'h0, e}, {16'h0, d});
    endtask
    task wr3(input logic [3:0] a, input logic [23:0] v);
        for (int i = 0; i < 3; i++) acrc_host_inst.wr(a + i[3:0], v[23 - 8 * i -: 8]);
    endtask
    task conv(input logic [23:0] r, input logic [23:0] e);
        @(negedge clk);
        {raw_valid, raw_data} = {1'h1, r};
        @(negedge clk);
        {raw_valid, raw_data} = {1'h0, ~r};
        @(negedge clk);
        chk("cal_valid", 24'h1, {23'h0, cal_valid});
        chk("cal_data", e, cal_data);
    endtask
    task fault(input logic e);
        repeat (3) @(negedge clk);
        chk("map_fault", {23'h0, e}, {23'h0, map_fault});
    endtask
    task tally_and_finish;
        if (bad_count == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {clk, rst_b, raw_valid, raw_data} = 27'h0;
        repeat (20) @(negedge clk);
        rst_b = 1'h1;
        for (int i = 8; i < 16; i++) rr(i[3:0], i == 12 ? 8'h40 : 8'h00);
        conv(24'h000100, 24'h000100);
        wr3(4'h9, 24'h000010);
        acrc_host_inst.wr(4'hC, 8'h20);
        rr(4'hC, 8'h20);
        rr(4'hB, 8'h10);
        conv(24'h000110, 24'h000080);
        conv(24'hFFFFFF, 24'hFFFFF7);
        wr3(4'h9, 24'h800000);
        wr3(4'hC, 24'h400000);
        conv(24'h7FFFFF, 24'h7FFFFF);
        wr3(4'h9, 24'h000000);
        wr3(4'hC, 24'hFFFFFF);
        conv(24'hC00000, 24'h800000);
        acrc_host_inst.wr(4'h8, 8'h02);
        c = acrc_host_inst.crc();
        acrc_host_inst.wr(4'hF, ~c);
        fault(1'h1);
        chk("header", 24'h1, {23'h0, status_header[5]});
        rr(4'h2, 8'hA1);
        acrc_host_inst.wr(4'hF, c);
        fault(1'h0);
        acrc_host_inst.wr(4'hF, ~c);
        acrc_host_inst.wr(4'h8, 8'h00);
        fault(1'h0);
        rr(4'hF, ~c);
        rr(4'h5, 8'h00);
        tally_and_finish;
    end
    // hang guard, about nine times the expected run
    initial begin
        #4000;
        bad_count++;
        tally_and_finish;
    end
endmodule // tb_top
bind acrc_cal_regmap acrc_cal_regmap_props #(.DATA_W(DATA_W)) acrc_cal_regmap_props_inst (.*);
`default_nettype wire
